/* rtl/cpu_exec_pkg.sv */
// constants, opcodes and instruction classes for the 4-bit cpu subset executor
// assumes byte-wide program memory and nibble-pair (byte) wide data memory ports
package cpu_exec_pkg;
  localparam int PC_W = 15;
  localparam int DA_W = 8;
  localparam logic [PC_W-1:0] PC_RST = 15'h0000;
  localparam logic [PC_W-1:0] PC_ONE = 15'h0001;
  localparam logic [DA_W-1:0] SP_RST = 8'h00;
  localparam logic [DA_W-1:0] SP_STEP2 = 8'h02;
  localparam logic [DA_W-1:0] SP_STEP4 = 8'h04;
  localparam logic [DA_W-1:0] SP_STEP6 = 8'h06;
  localparam logic [3:0] NIB_ZERO = 4'h0;
  localparam logic [3:0] NIB_ONE = 4'h1;
  localparam logic [3:0] NIB_FULL = 4'hf;
  // first-byte opcodes
  localparam logic [7:0] OP_LD_DEC = 8'h8b;
  localparam logic [7:0] OP_LD_INC = 8'h8a;
  localparam logic [7:0] OP_LONG_JMP = 8'hd8;
  localparam logic [7:0] OP_NO_OPER = 8'ha0;
  localparam logic [7:0] OP_OR_PTR = 8'h3a;
  localparam logic [7:0] OP_PRE_DC = 8'hdc;
  localparam logic [7:0] OP_PRE_DD = 8'hdd;
  localparam logic [7:0] OP_CLR_CARRY = 8'he6;
  localparam logic [4:0] STK_PAIR_TOP = 5'h05;
  localparam logic [7:0] REF_LO = 8'h20;
  localparam logic [7:0] REF_HI = 8'h7f;
  localparam logic [3:0] RED_NIB = 4'hb;
  // second-byte encodings
  localparam logic [3:0] OR_IM_TOP = 4'h2;
  localparam logic [4:0] OR_ACC_PAIR_TOP = 5'h05;
  localparam logic [4:0] OR_PAIR_ACC_TOP = 5'h04;
  localparam logic [7:0] POP_SB = 8'h66;
  localparam logic [7:0] PUSH_SB = 8'h67;
  // table entry kinds in the top two bits
  localparam logic [1:0] ENT_JUMP = 2'h0;
  localparam logic [1:0] ENT_CALL = 2'h1;
  localparam logic [1:0] LEN1 = 2'h1;
  localparam logic [1:0] LEN2 = 2'h2;
  localparam logic [1:0] LEN3 = 2'h3;
  localparam logic [1:0] WE_NONE = 2'h0;
  localparam logic [1:0] WE_BOTH = 2'h3;

  typedef enum logic [3:0] {
    CL_NO_OPER, CL_LD_DEC, CL_LD_INC, CL_LONG_JMP, CL_OR_PTR, CL_PRE_DC, CL_PRE_DD,
    CL_POP, CL_PUSH, CL_CLR_CARRY, CL_REF, CL_RED, CL_OTHER
  } iclass_e;
endpackage

/* rtl/instr_class.sv */
// first-byte classifier: instruction class and length in bytes
// assumes the opcode byte is stable for the whole cycle
`timescale 1ns/1ps
`default_nettype none
module instr_class (
  input wire logic [7:0] i_opcode,
  output var cpu_exec_pkg::iclass_e o_cls,
  output var logic [1:0] o_len
);
  import cpu_exec_pkg::*;

  always_comb begin
    o_len = LEN1;
    if (i_opcode == OP_LD_DEC) begin
      o_cls = CL_LD_DEC;
    end else if (i_opcode == OP_LD_INC) begin
      o_cls = CL_LD_INC;
    end else if (i_opcode == OP_LONG_JMP) begin
      o_cls = CL_LONG_JMP;
      o_len = LEN3;
    end else if (i_opcode == OP_NO_OPER) begin
      o_cls = CL_NO_OPER;
    end else if (i_opcode == OP_OR_PTR) begin
      o_cls = CL_OR_PTR;
    end else if (i_opcode == OP_PRE_DC) begin
      o_cls = CL_PRE_DC;
      o_len = LEN2;
    end else if (i_opcode == OP_PRE_DD) begin
      o_cls = CL_PRE_DD;
      o_len = LEN2;
    end else if (i_opcode == OP_CLR_CARRY) begin
      o_cls = CL_CLR_CARRY;
    end else if (i_opcode[7:3] == STK_PAIR_TOP) begin
      o_cls = i_opcode[0] ? CL_PUSH : CL_POP;
    end else if (i_opcode >= REF_LO && i_opcode <= REF_HI) begin
      o_cls = CL_REF;
    end else if (i_opcode[7:4] == RED_NIB) begin
      o_cls = CL_RED;
    end else begin
      o_cls = CL_OTHER;
    end
  end
endmodule
`default_nettype wire

/* rtl/cpu_subset_exec.sv */
// executes a subset of a 4-bit cpu instruction set, one machine cycle per clock
// assumes asynchronous-read program memory and data memory (pair at even address)
// Function
// - load-decrement loads A, L-1, skip at 0FH
// - load-increment loads A, L+1, skip at 0H
// - long jump: three bytes, loads all 15 bits
// - no-operation: one cycle, only advances pc
// - OR into destination, source unchanged
// - pop: low at SP, high above, SP+2
// - push: high at SP-1, low SP-2, SP-2
// - clear-carry forces carry to zero
// - table dispatch: 3 cycles, 4 for call
// - jump entry: pc from low nibble, next byte
// - call entry: push six nibbles, SP-6, jump
// - other entries execute in place
// - redundancy instruction after a jump or call entry is skipped
// - entry address from dispatch code nibbles
`timescale 1ns/1ps
`default_nettype none
module cpu_subset_exec (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  output var logic [cpu_exec_pkg::PC_W-1:0] o_pm_addr,
  input wire logic [7:0] i_pm_data,
  output var logic [cpu_exec_pkg::DA_W-1:0] o_dm_raddr,
  input wire logic [7:0] i_dm_rdata,
  output var logic [cpu_exec_pkg::DA_W-1:0] o_dm_waddr,
  output var logic [7:0] o_dm_wdata,
  output var logic [1:0] o_dm_we,
  output var logic o_carry
);
  import cpu_exec_pkg::*;

  typedef enum logic [3:0] {
    ST_FETCH, ST_LOAD, ST_BYTE2, ST_POP, ST_LONG2, ST_LONG3, ST_SKIP, ST_REF1, ST_REF2, ST_REF3
  } state_e;

  state_e st_r, st_nxt;
  logic [PC_W-1:0] pc_r, pc_nxt, pm_r, pm_nxt, ref_ret_r, ref_ret_nxt, ref_end_r, ref_end_nxt;
  logic [DA_W-1:0] sp_r, sp_nxt, ra_r, ra_nxt, wa_r, wa_nxt;
  logic [7:0] wd_r, wd_nxt, hold_r, hold_nxt, ent_r, ent_nxt;
  logic [1:0] we_r, we_nxt, skc_r, skc_nxt, pair_r, pair_nxt;
  logic [3:0] regs_r [8];
  logic [3:0] regs_nxt [8];
  logic [3:0] mbank_r, mbank_nxt, rbank_r, rbank_nxt;
  logic carry_r, carry_nxt, skip_r, skip_nxt, red_r, red_nxt, in_ref_r, in_ref_nxt, sbp_r, sbp_nxt;
  logic xbank_en_r, xreg_en_r;
  iclass_e cls;
  logic [1:0] len;
  logic [PC_W-1:0] seq_pc, next_pc;
  logic seq_hit, adv, exec;
  logic [3:0] ptr_nib, new_l;
  logic [7:0] tbl, dm_pair;

  instr_class u_cls (
    .i_opcode(i_pm_data),
    .o_cls(cls),
    .o_len(len)
  );

  // forward a write still in flight to the pair being read
  assign dm_pair = (we_r != WE_NONE && wa_r == {ra_r[DA_W-1:1], 1'b0}) ? wd_r : i_dm_rdata;
  assign ptr_nib = ra_r[0] ? dm_pair[7:4] : dm_pair[3:0];
  assign exec = (st_r == ST_FETCH) && !skip_r && !(red_r && cls == CL_RED);
  assign tbl = {i_pm_data[7:4], NIB_ZERO} + {3'h0, i_pm_data[3:0], 1'b0};

  always_comb begin
    st_nxt = st_r;
    pc_nxt = pc_r;
    pm_nxt = pm_r;
    sp_nxt = sp_r;
    regs_nxt = regs_r;
    mbank_nxt = mbank_r;
    rbank_nxt = rbank_r;
    carry_nxt = carry_r;
    skip_nxt = skip_r;
    red_nxt = red_r;
    in_ref_nxt = in_ref_r;
    ref_ret_nxt = ref_ret_r;
    ref_end_nxt = ref_end_r;
    hold_nxt = hold_r;
    ent_nxt = ent_r;
    skc_nxt = skc_r;
    pair_nxt = pair_r;
    sbp_nxt = sbp_r;
    wa_nxt = wa_r;
    wd_nxt = wd_r;
    we_nxt = WE_NONE;
    adv = 1'b0;
    new_l = regs_r[2];
    seq_pc = pc_r + PC_ONE;
    seq_hit = in_ref_r && (seq_pc == ref_end_r);
    next_pc = seq_hit ? ref_ret_r : seq_pc;
    unique case (st_r)
      ST_FETCH: begin
        red_nxt = 1'b0;
        if (!exec) begin
          skip_nxt = 1'b0;
          if (len == LEN1) begin
            adv = 1'b1;
          end else begin
            pc_nxt = seq_pc;
            pm_nxt = seq_pc;
            skc_nxt = len - LEN1;
            st_nxt = ST_SKIP;
          end
        end else begin
          unique case (cls)
            CL_LD_DEC, CL_LD_INC: begin
              hold_nxt = i_pm_data;
              st_nxt = ST_LOAD;
            end
            CL_LONG_JMP, CL_PRE_DC, CL_PRE_DD: begin
              hold_nxt = i_pm_data;
              pc_nxt = seq_pc;
              pm_nxt = seq_pc;
              st_nxt = (cls == CL_LONG_JMP) ? ST_LONG2 : ST_BYTE2;
            end
            CL_OR_PTR: begin
              regs_nxt[0] = regs_r[0] | ptr_nib;
              adv = 1'b1;
            end
            CL_POP: begin
              pair_nxt = i_pm_data[2:1];
              sbp_nxt = 1'b0;
              st_nxt = ST_POP;
            end
            CL_PUSH: begin
              wa_nxt = sp_r - SP_STEP2;
              wd_nxt = {regs_r[{i_pm_data[2:1], 1'b1}], regs_r[{i_pm_data[2:1], 1'b0}]};
              we_nxt = WE_BOTH;
              sp_nxt = sp_r - SP_STEP2;
              adv = 1'b1;
            end
            CL_CLR_CARRY: begin
              carry_nxt = 1'b0;
              adv = 1'b1;
            end
            CL_REF: begin
              ref_ret_nxt = next_pc;
              pm_nxt = {7'h00, tbl};
              st_nxt = ST_REF1;
            end
            default: adv = 1'b1;
          endcase
        end
      end
      ST_LOAD: begin
        regs_nxt[0] = ptr_nib;
        new_l = (hold_r == OP_LD_DEC) ? regs_r[2] - NIB_ONE : regs_r[2] + NIB_ONE;
        regs_nxt[2] = new_l;
        skip_nxt = (hold_r == OP_LD_DEC) ? (new_l == NIB_FULL) : (new_l == NIB_ZERO);
        adv = 1'b1;
        st_nxt = ST_FETCH;
      end
      ST_BYTE2: begin
        adv = 1'b1;
        st_nxt = ST_FETCH;
        if (hold_r == OP_PRE_DD) begin
          if (i_pm_data[7:4] == OR_IM_TOP) begin
            regs_nxt[0] = regs_r[0] | i_pm_data[3:0];
          end else if (i_pm_data == POP_SB) begin
            sbp_nxt = 1'b1;
            adv = 1'b0;
            st_nxt = ST_POP;
          end else if (i_pm_data == PUSH_SB) begin
            wa_nxt = sp_r - SP_STEP2;
            wd_nxt = {mbank_r, rbank_r};
            we_nxt = WE_BOTH;
            sp_nxt = sp_r - SP_STEP2;
          end
        end else if (i_pm_data[7:3] == OR_ACC_PAIR_TOP) begin
          regs_nxt[0] = regs_r[0] | regs_r[{i_pm_data[2:1], 1'b0}];
          regs_nxt[1] = regs_r[1] | regs_r[{i_pm_data[2:1], 1'b1}];
        end else if (i_pm_data[7:3] == OR_PAIR_ACC_TOP) begin
          regs_nxt[{i_pm_data[2:1], 1'b0}] = regs_r[{i_pm_data[2:1], 1'b0}] | regs_r[0];
          regs_nxt[{i_pm_data[2:1], 1'b1}] = regs_r[{i_pm_data[2:1], 1'b1}] | regs_r[1];
        end
      end
      ST_POP: begin
        if (sbp_r) begin
          rbank_nxt = i_dm_rdata[3:0];
          mbank_nxt = i_dm_rdata[7:4];
        end else begin
          regs_nxt[{pair_r, 1'b0}] = i_dm_rdata[3:0];
          regs_nxt[{pair_r, 1'b1}] = i_dm_rdata[7:4];
        end
        sp_nxt = sp_r + SP_STEP2;
        adv = 1'b1;
        st_nxt = ST_FETCH;
      end
      ST_LONG2: begin
        hold_nxt = i_pm_data;
        pc_nxt = seq_pc;
        pm_nxt = seq_pc;
        st_nxt = ST_LONG3;
      end
      ST_LONG3: begin
        pc_nxt = {hold_r[6:0], i_pm_data};
        pm_nxt = {hold_r[6:0], i_pm_data};
        in_ref_nxt = 1'b0;
        st_nxt = ST_FETCH;
      end
      ST_SKIP: begin
        skc_nxt = skc_r - LEN1;
        if (skc_r == LEN1) begin
          adv = 1'b1;
          st_nxt = ST_FETCH;
        end else begin
          pc_nxt = seq_pc;
          pm_nxt = seq_pc;
        end
      end
      ST_REF1: begin
        ent_nxt = i_pm_data;
        if (i_pm_data[7:6] == ENT_CALL) begin
          wa_nxt = sp_r - SP_STEP2;
          wd_nxt = {NIB_ZERO, 2'h0, xbank_en_r, xreg_en_r};
          we_nxt = WE_BOTH;
        end
        pm_nxt = pm_r + PC_ONE;
        st_nxt = ST_REF2;
      end
      ST_REF2: begin
        st_nxt = ST_FETCH;
        unique case (ent_r[7:6])
          ENT_JUMP: begin
            pc_nxt = {3'h0, ent_r[3:0], i_pm_data};
            pm_nxt = {3'h0, ent_r[3:0], i_pm_data};
            in_ref_nxt = 1'b0;
            red_nxt = 1'b1;
          end
          ENT_CALL: begin
            wa_nxt = sp_r - SP_STEP4;
            wd_nxt = ref_ret_r[7:0];
            we_nxt = WE_BOTH;
            hold_nxt = i_pm_data;
            st_nxt = ST_REF3;
          end
          default: begin
            pc_nxt = pm_r - PC_ONE;
            pm_nxt = pm_r - PC_ONE;
            ref_end_nxt = pm_r + PC_ONE;
            in_ref_nxt = 1'b1;
          end
        endcase
      end
      ST_REF3: begin
        wa_nxt = sp_r - SP_STEP6;
        wd_nxt = {1'b0, ref_ret_r[14:12], ref_ret_r[11:8]};
        we_nxt = WE_BOTH;
        sp_nxt = sp_r - SP_STEP6;
        pc_nxt = {1'b0, ent_r[5:0], hold_r};
        pm_nxt = {1'b0, ent_r[5:0], hold_r};
        in_ref_nxt = 1'b0;
        red_nxt = 1'b1;
        st_nxt = ST_FETCH;
      end
    endcase
    if (adv) begin
      pc_nxt = next_pc;
      pm_nxt = next_pc;
      if (seq_hit) begin
        in_ref_nxt = 1'b0;
      end
    end
    ra_nxt = (st_nxt == ST_POP) ? sp_r : {regs_nxt[3], regs_nxt[2]};
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      st_r <= ST_FETCH;
      pc_r <= PC_RST;
      pm_r <= PC_RST;
      sp_r <= SP_RST;
      for (int i = 0; i < 8; i++) begin
        regs_r[i] <= NIB_ZERO;
      end
      mbank_r <= NIB_ZERO;
      rbank_r <= NIB_ZERO;
      {carry_r, skip_r, red_r, in_ref_r, sbp_r, xbank_en_r, xreg_en_r} <= '0;
      ref_ret_r <= PC_RST;
      ref_end_r <= PC_RST;
      hold_r <= '0;
      ent_r <= '0;
      skc_r <= '0;
      pair_r <= '0;
      ra_r <= SP_RST;
      wa_r <= SP_RST;
      wd_r <= '0;
      we_r <= WE_NONE;
    end else begin
      st_r <= st_nxt;
      pc_r <= pc_nxt;
      pm_r <= pm_nxt;
      sp_r <= sp_nxt;
      regs_r <= regs_nxt;
      mbank_r <= mbank_nxt;
      rbank_r <= rbank_nxt;
      {carry_r, skip_r, red_r, in_ref_r, sbp_r} <= {carry_nxt, skip_nxt, red_nxt, in_ref_nxt, sbp_nxt};
      ref_ret_r <= ref_ret_nxt;
      ref_end_r <= ref_end_nxt;
      hold_r <= hold_nxt;
      ent_r <= ent_nxt;
      skc_r <= skc_nxt;
      pair_r <= pair_nxt;
      ra_r <= ra_nxt;
      wa_r <= wa_nxt;
      wd_r <= wd_nxt;
      we_r <= we_nxt;
    end
  end

  assign o_pm_addr = pm_r;
  assign o_dm_raddr = ra_r;
  assign o_dm_waddr = wa_r;
  assign o_dm_wdata = wd_r;
  assign o_dm_we = we_r;
  assign o_carry = carry_r;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);

  sequence s_ld_dec;
    exec && cls == CL_LD_DEC ##1 st_r == ST_LOAD;
  endsequence
  sequence s_long_jmp;
    exec && cls == CL_LONG_JMP ##1 st_r == ST_LONG2 ##1 st_r == ST_LONG3;
  endsequence
  sequence s_ref_call;
    exec && cls == CL_REF ##1 st_r == ST_REF1 ##1 st_r == ST_REF2 && ent_r[7:6] == ENT_CALL;
  endsequence

  a_ld_dec_step: assert property (s_ld_dec |=> regs_r[2] == $past(regs_r[2]) - NIB_ONE && skip_r == (regs_r[2] == NIB_FULL))
    else $error("load-decrement pointer step or skip wrong");
  a_ld_inc_step: assert property (exec && cls == CL_LD_INC |=> ##1 regs_r[2] == $past(regs_r[2], 2) + NIB_ONE && $stable(carry_r))
    else $error("load-increment pointer step or carry wrong");
  a_long_target: assert property (s_long_jmp |=> pm_r == {$past(hold_r[6:0]), $past(i_pm_data)} && st_r == ST_FETCH)
    else $error("long jump target wrong");
  a_idle_advance: assert property (exec && cls == CL_NO_OPER && !in_ref_r |=> pc_r == $past(pc_r) + PC_ONE && st_r == ST_FETCH)
    else $error("no-operation did not advance by one");
  a_or_mem: assert property (exec && cls == CL_OR_PTR |=> regs_r[0] == ($past(regs_r[0]) | $past(ptr_nib)))
    else $error("or with memory wrong");
  a_pop_sp: assert property (st_r == ST_POP |=> sp_r == $past(sp_r) + SP_STEP2 && st_r == ST_FETCH)
    else $error("pop stack pointer wrong");
  a_push_write: assert property (exec && cls == CL_PUSH |=> we_r == WE_BOTH && wa_r == $past(sp_r) - SP_STEP2 && sp_r == wa_r)
    else $error("push write or stack pointer wrong");
  a_carry_clear: assert property (exec && cls == CL_CLR_CARRY |=> !carry_r && st_r == ST_FETCH)
    else $error("carry not cleared");
  a_ref_cycles: assert property (exec && cls == CL_REF |=> st_r == ST_REF1 ##1 st_r == ST_REF2 ##1 (st_r == ST_FETCH || st_r == ST_REF3))
    else $error("dispatch cycle count wrong");
  a_call_sp: assert property (s_ref_call |=> ##1 sp_r == $past(sp_r, 2) - SP_STEP6 && st_r == ST_FETCH)
    else $error("table call stack pointer wrong");
  a_skip_quiet: assert property (st_r == ST_FETCH && skip_r && len == LEN1 |=> $stable(carry_r) && $stable(sp_r) && we_r == WE_NONE)
    else $error("skipped instruction had an effect");
endmodule
`default_nettype wire

/* test/prog_data_mem.sv */
// program memory and nibble data memory facing the cpu subset executor
// assumes asynchronous reads and data writes on the clock edge ending a write cycle
`timescale 1ns/1ps
`default_nettype none
module prog_data_mem (
  input wire logic i_clk,
  input wire logic [14:0] i_pm_addr,
  output logic [7:0] o_pm_data,
  input wire logic [7:0] i_dm_raddr,
  output logic [7:0] o_dm_rdata,
  input wire logic [7:0] i_dm_waddr,
  input wire logic [7:0] i_dm_wdata,
  input wire logic [1:0] i_dm_we
);
  logic [7:0] pm [0:32767];
  logic [3:0] dm [0:255];
  logic [15:0] wr_log [$];

  assign o_pm_data = pm[i_pm_addr];
  // pair at the even address: low nibble even, high nibble odd
  assign o_dm_rdata = {dm[{i_dm_raddr[7:1], 1'b1}], dm[{i_dm_raddr[7:1], 1'b0}]};

  always @(posedge i_clk) begin
    if (i_dm_we != 2'h0) begin
      dm[i_dm_waddr] <= i_dm_wdata[3:0];
      dm[i_dm_waddr + 8'h01] <= i_dm_wdata[7:4];
      wr_log.push_back({i_dm_waddr, i_dm_wdata});
    end
  end
endmodule
`default_nettype wire

/* test/test_cpu_subset_exec.sv */
// self-checking bench for the cpu subset executor: random data memory and operands
// assumes the memory model answers combinationally and logs every data write
`timescale 1ns/1ps
`default_nettype none
module test_cpu_subset_exec;
  import cpu_exec_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [14:0] pm_addr;
  logic [7:0] pm_data;
  logic [7:0] dm_raddr;
  logic [7:0] dm_rdata;
  logic [7:0] dm_waddr;
  logic [7:0] dm_wdata;
  logic [1:0] dm_we;
  logic carry;
  int err_total = 0;
  int compares = 0;
  int cyc = 0;
  int seed = 32'h92f34d79;
  int first_seen [int];
  logic [3:0] ref_dm [0:255];
  logic [15:0] exp_log [$];
  logic [7:0] sp;

  always #12.5 clk = ~clk;

  cpu_subset_exec uut (.i_ref_clk(clk), .i_srst(srst), .o_pm_addr(pm_addr), .i_pm_data(pm_data),
    .o_dm_raddr(dm_raddr), .i_dm_rdata(dm_rdata), .o_dm_waddr(dm_waddr), .o_dm_wdata(dm_wdata),
    .o_dm_we(dm_we), .o_carry(carry));
  prog_data_mem mem (.i_clk(clk), .i_pm_addr(pm_addr), .o_pm_data(pm_data), .i_dm_raddr(dm_raddr),
    .o_dm_rdata(dm_rdata), .i_dm_waddr(dm_waddr), .i_dm_wdata(dm_wdata), .i_dm_we(dm_we));

  always @(posedge clk) begin
    cyc++;
    if (srst)
      first_seen.delete();
    else if (!first_seen.exists(int'(pm_addr)))
      first_seen[int'(pm_addr)] = cyc;
    if (cyc >= 20000) begin
      err_total++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check_word(string what, logic [15:0] exp, logic [15:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_count(string what, int exp, int got);
    compares++;
    if (got != exp) begin
      err_total++;
      $display("BAD %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  function automatic int span(int a, int b);
    if (!first_seen.exists(a) || !first_seen.exists(b))
      return -1;
    return first_seen[b] - first_seen[a];
  endfunction

  function automatic void wr(logic [7:0] a, logic [7:0] d);
    exp_log.push_back({a, d});
    ref_dm[a] = d[3:0];
    ref_dm[a + 8'h01] = d[7:4];
  endfunction

  function automatic void push(logic [7:0] d);
    sp = sp - 8'h02;
    wr(sp, d);
  endfunction

  // expected data writes of the whole program, from the starting data memory
  function automatic void predict(logic [3:0] im);
    logic [3:0] a;
    logic [3:0] l;
    logic [3:0] h;
    exp_log.delete();
    l = ref_dm[0];
    h = ref_dm[1];
    sp = 8'h02;
    a = ref_dm[{h, l}];
    l = l + 4'h1;
    if (l != 4'h0) push({4'h0, a});
    push({h, l});
    a = ref_dm[{h, l}];
    l = l - 4'h1;
    if (l != 4'hf) push({4'h0, a});
    a = a | ref_dm[{h, l}];
    push({4'h0, a});
    a = a | im;
    push({4'h0, a});
    wr(sp - 8'h02, 8'h00);
    wr(sp - 8'h04, 8'h01);
    wr(sp - 8'h06, 8'h41);
    sp = sp - 8'h06;
    push(8'h00);
  endfunction

  task automatic pb(int a, logic [7:0] d);
    mem.pm[a] = d;
  endtask

  task automatic load_prog();
    for (int i = 0; i < 32768; i++) mem.pm[i] = 8'ha0;
    pb(0, 8'h2a); pb(1, 8'h8a); pb(2, 8'h29); pb(3, 8'h2b); pb(4, 8'h8b); pb(5, 8'h29);
    pb(6, 8'h3a); pb(7, 8'h29); pb(8, 8'hdd); pb('ha, 8'h29); pb('hb, 8'he6); pb('hc, 8'ha0);
    pb('hd, 8'hd8); pb('he, 8'h41); pb('hf, 8'h00);
    pb('h4100, 8'h21);
    pb('h20, 8'h05); pb('h21, 8'h40);
    pb('h22, 8'h41); pb('h23, 8'h23);
    pb('h2e, 8'hdd); pb('h2f, 8'h67);
    pb('h123, 8'h20);
    pb('h540, 8'h27); pb('h541, 8'hdd); pb('h542, 8'h66);
    pb('h543, 8'hd8); pb('h544, 8'h05); pb('h545, 8'h43);
  endtask

  initial begin
    logic [3:0] im;
    load_prog();
    for (int it = 0; it < 8; it++) begin
      srst <= 1'b1;
      im = 4'($random(seed));
      pb(9, {4'h2, im});
      for (int i = 0; i < 256; i++) begin
        ref_dm[i] = 4'($random(seed));
        mem.dm[i] = ref_dm[i];
      end
      if (it == 0) ref_dm[0] = 4'hf;
      if (it == 1) ref_dm[0] = 4'he;
      mem.dm[0] = ref_dm[0];
      repeat (10) @(posedge clk);
      check_word("reset pm_addr", 16'h0000, {1'b0, pm_addr});
      check_word("reset we", 16'h0000, {14'h0000, dm_we});
      check_word("reset carry", 16'h0000, {15'h0000, carry});
      mem.wr_log.delete();
      predict(im);
      srst <= 1'b0;
      repeat (80) @(posedge clk);
      check_count("write count", exp_log.size(), mem.wr_log.size());
      foreach (exp_log[i]) if (i < mem.wr_log.size()) check_word("write", exp_log[i], mem.wr_log[i]);
      check_word("carry", 16'h0000, {15'h0000, carry});
      check_count("pop cycles", 2, span(0, 1));
      check_count("load inc cycles", 3, span(1, 3));
      check_count("load dec cycles", 3, span(4, 6));
      check_count("or mem cycles", 1, span(6, 7));
      check_count("or imm cycles", 2, span(8, 'ha));
      check_count("clear carry cycles", 1, span('hb, 'hc));
      check_count("nop cycles", 1, span('hc, 'hd));
      check_count("long jump cycles", 3, span('hd, 'h4100));
      check_count("call entry cycles", 4, span('h4100, 'h123));
      check_count("jump entry cycles", 3, span('h123, 'h540));
      check_count("in place cycles", 5, span('h540, 'h541));
      check_count("loop reached", 1, int'(first_seen.exists('h543)));
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
